//--- shared/tpc_pkg.sv
// constants, types and helpers shared by the timer pwm channel block
`default_nettype none
package tpc_pkg;
   localparam int NCH = 4;
   localparam int CW = 16;
   localparam int PW = 7;

   // register byte addresses
   localparam logic [7:0] OFF_TSC = 8'h00;
   localparam logic [7:0] OFF_CNT = 8'h04;
   localparam logic [7:0] OFF_MODH = 8'h08;
   localparam logic [7:0] OFF_MODL = 8'h0c;
   localparam logic [7:0] OFF_CH_BASE = 8'h10;
   localparam logic [7:0] CH_STRIDE = 8'h10;
   localparam logic [7:0] CH_CTL = 8'h00;
   localparam logic [7:0] CH_CMPH = 8'h04;
   localparam logic [7:0] CH_CMPL = 8'h08;
   localparam logic [7:0] OFF_BRK = 8'h50;

   // timer_ctrl_stat fields
   localparam int TSC_OVF = 7;
   localparam int TSC_OIE = 6;
   localparam int TSC_HALT = 5;
   localparam int TSC_CLR = 4;
   localparam int PS_MSB = 2;
   // channel_ctrl_stat flag position, break_flag_ctrl field
   localparam int CH_FLAG = 7;
   localparam int CH_FIELD_MSB = 6;
   localparam int BRK_BREAK_CLEAR_ENABLE = 7;

   localparam logic [CW-1:0] MOD_RST = 16'hffff;
   localparam logic [2:0] PS_RST = 3'h0;
   localparam logic [2:0] PS_EXT = 3'h7;
   localparam logic HALT_RST = 1'b1;

   // edge/level codes
   localparam logic [1:0] ELS_TGL = 2'h1;
   localparam logic [1:0] ELS_CLR = 2'h2;
   localparam logic [1:0] ELS_SET = 2'h3;

   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_UNBUF = 2'b01,
      MODE_BUF = 2'b10
   } tpc_mode_e;

   // channel_ctrl_stat bits 6..0
   typedef struct packed {
      logic irqEn;
      logic link;
      logic modeLsb;
      logic [1:0] edgeLevel;
      logic toggleOnOvf;
      logic fullDuty;
   } tpc_chctl_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } tpc_aphase_s;

   // link bit outranks mode lsb, only on a pair lead
   function automatic tpc_mode_e tpc_decode_mode(input tpc_chctl_s c,
                                                 input logic lead);
      if (c.link && lead) begin
         return MODE_BUF;
      end else if (c.modeLsb) begin
         return MODE_UNBUF;
      end
      return MODE_OFF;
   endfunction : tpc_decode_mode
endpackage : tpc_pkg
`default_nettype wire

//--- logic/tpc_counter.sv
// prescaler and 16-bit modulo up-counter of the timer
`timescale 1ns/1ps
`default_nettype none
module tpc_counter
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic halt,
   input wire logic clear,
   input wire logic [2:0] prescale,
   input wire logic [CW-1:0] modulo,
   output logic [CW-1:0] count,
   output logic tick,
   output logic ovf
);
   logic [PW-1:0] pre_q;
   logic [CW-1:0] cnt_q;
   logic [PW-1:0] mask;

   // count tick when all prescaler bits below the select are ones
   assign mask = PW'((8'h01 << prescale) - 8'h01);
   assign tick = !halt && (prescale != PS_EXT) && ((pre_q & mask) == mask);
   assign ovf = tick && (cnt_q == modulo);
   assign count = cnt_q;

   // prescaler; clear acts even while halted
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
      end else if (clear) begin
         pre_q <= '0;
      end else if (!halt) begin
         pre_q <= pre_q + PW'(1);
      end
   end

   // counter wraps to zero after reaching the modulo
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (clear) begin
         cnt_q <= '0;
      end else if (ovf) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end
endmodule : tpc_counter
`default_nettype wire

//--- logic/tpc_channel.sv
// output stage of one timer channel
`timescale 1ns/1ps
`default_nettype none
module tpc_channel
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic active,
   input wire logic ovf,
   input wire logic match,
   input wire logic [1:0] edgeLevel,
   input wire logic toggleOnOvf,
   input wire logic fullDuty,
   output logic pwmOut
);
   // idle or freed channels rest low; match outranks overflow toggle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pwmOut <= 1'b0;
      end else if (!active) begin
         pwmOut <= 1'b0;
      end else if (fullDuty) begin
         pwmOut <= (edgeLevel != ELS_SET);
      end else if (match) begin
         unique case (edgeLevel)
            ELS_CLR: pwmOut <= 1'b0;
            ELS_SET: pwmOut <= 1'b1;
            ELS_TGL: pwmOut <= !pwmOut;
            default: pwmOut <= pwmOut;
         endcase
      end else if (ovf && toggleOnOvf) begin
         pwmOut <= !pwmOut;
      end
   end
endmodule : tpc_channel
`default_nettype wire

//--- logic/tpc_timer_pwm.sv
// four-channel timer pwm block with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - unbuffered compare written directly, no shadow
// - low link joins channels 0/1 onto 0
// - high link joins channels 2/3 onto 2
// - last written pair register controls from overflow
// - linked lead reports; odd channel freed, unused
// - link bit outranks mode lsb on lead
// - mode 01 unbuffered, 10 buffered
// - edge/level 10 clears, 11 sets on match
// - toggle on overflow when enabled; edge/level 01 toggles on match
// - full duty bit forces 100 percent duty, 0 percent with edge/level 11
// - overflow flag at modulo, irq when enabled
// - channel flag on compare, irq when enabled
// - timer runs in wait; irqs wake
// - stop halts timer, keeps all state
// - break halts the counter
// - break protects flags unless clear enable set
// - armed clear survives break, finishes after
// - period is overflow spacing, width to match
// - flag clear: read set, write zero
// - modulo high write inhibits overflow until low
module tpc_timer_pwm
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic breakActive,
   input wire logic stopMode,
   output logic [NCH-1:0] chanOut,
   output logic ovfIrq,
   output logic [NCH-1:0] chanIrq,
   output logic wakeReq
);
   localparam int NPAIR = NCH / 2;

   tpc_aphase_s ap_q;
   logic apTake;
   logic rdNow;
   logic wrEn;
   logic [7:0] wdat;
   logic [7:0] ra;
   logic [31:0] rdData;
   logic ovfIe_q;
   logic halt_q;
   logic [2:0] ps_q;
   logic clrPulse_q;
   logic [CW-1:0] mod_q;
   logic modInhibit_q;
   logic break_clear_enable_q;
   logic ovfFlag_q;
   logic ovfArm_q;
   logic flagOps;
   logic ovfSet;
   logic wrTsc;
   logic [CW-1:0] count;
   logic tick;
   logic ovfEv;
   tpc_chctl_s ctl [NCH];
   logic [CW-1:0] cmp [NCH];
   logic [NCH-1:0] chFlag;
   logic [NPAIR-1:0] linked;
   logic [NPAIR-1:0] actOdd;

   // register hit test for one channel's register
   function automatic logic chHit(input logic [7:0] a, input int c,
                                  input logic [7:0] sub);
      return a == 8'(OFF_CH_BASE + 8'(c) * CH_STRIDE + sub);
   endfunction : chHit

   // ahb-lite address phase; the slave never inserts wait states
   assign apTake = hsel && hready && htrans[1];
   assign rdNow = apTake && !hwrite;
   assign ra = haddr[7:0];
   assign wrEn = ap_q.valid && ap_q.write;
   assign wdat = hwdata[7:0];
   assign wrTsc = wrEn && (ap_q.addr == OFF_TSC);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ap_q <= '0;
      end else begin
         ap_q.valid <= apTake;
         ap_q.write <= hwrite;
         ap_q.addr <= haddr[7:0];
      end
   end

   // read data registered at the address phase edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hrdata <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= rdNow ? rdData : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdData = '0;
      if (ra == OFF_TSC) begin
         rdData[TSC_OVF] = ovfFlag_q;
         rdData[TSC_OIE] = ovfIe_q;
         rdData[TSC_HALT] = halt_q;
         rdData[PS_MSB:0] = ps_q;
      end else if (ra == OFF_CNT) begin
         rdData[CW-1:0] = count;
      end else if (ra == OFF_MODH) begin
         rdData[7:0] = mod_q[15:8];
      end else if (ra == OFF_MODL) begin
         rdData[7:0] = mod_q[7:0];
      end else if (ra == OFF_BRK) begin
         rdData[BRK_BREAK_CLEAR_ENABLE] = break_clear_enable_q;
      end
      for (int c = 0; c < NCH; c++) begin
         if (chHit(ra, c, CH_CTL)) begin
            rdData[7:0] = {chFlag[c], ctl[c]};
         end else if (chHit(ra, c, CH_CMPH)) begin
            rdData[7:0] = cmp[c][15:8];
         end else if (chHit(ra, c, CH_CMPL)) begin
            rdData[7:0] = cmp[c][7:0];
         end
      end
   end

   // timer control; clear bit is a one-cycle pulse and reads zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovfIe_q <= 1'b0;
         halt_q <= HALT_RST;
         ps_q <= PS_RST;
         clrPulse_q <= 1'b0;
      end else begin
         clrPulse_q <= wrTsc && wdat[TSC_CLR];
         if (wrTsc) begin
            ovfIe_q <= wdat[TSC_OIE];
            halt_q <= wdat[TSC_HALT];
            ps_q <= wdat[PS_MSB:0];
         end
      end
   end

   // modulo; high byte write holds off overflow until low byte
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mod_q <= MOD_RST;
         modInhibit_q <= 1'b0;
      end else if (wrEn && ap_q.addr == OFF_MODH) begin
         mod_q[15:8] <= wdat;
         modInhibit_q <= 1'b1;
      end else if (wrEn && ap_q.addr == OFF_MODL) begin
         mod_q[7:0] <= wdat;
         modInhibit_q <= 1'b0;
      end
   end

   // break flag control
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         break_clear_enable_q <= 1'b0;
      end else if (wrEn && ap_q.addr == OFF_BRK) begin
         break_clear_enable_q <= wdat[BRK_BREAK_CLEAR_ENABLE];
      end
   end

   // stop and break freeze the count but keep every register
   tpc_counter u_counter (
      .mclk(mclk),
      .rst(rst),
      .halt(halt_q || stopMode || breakActive),
      .clear(clrPulse_q),
      .prescale(ps_q),
      .modulo(mod_q),
      .count(count),
      .tick(tick),
      .ovf(ovfEv)
   );

   // accesses may touch flags outside break or with clear enable
   assign flagOps = !breakActive || break_clear_enable_q;
   assign ovfSet = ovfEv && !modInhibit_q;

   // overflow clear arms on a read that sees it set
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovfArm_q <= 1'b0;
      end else if (ovfSet) begin
         ovfArm_q <= 1'b0;
      end else if (rdNow && ra == OFF_TSC && ovfFlag_q && flagOps) begin
         ovfArm_q <= 1'b1;
      end else if (wrTsc && flagOps) begin
         ovfArm_q <= 1'b0;
      end
   end

   // a new overflow wins over a clear in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovfFlag_q <= 1'b0;
      end else if (ovfSet) begin
         ovfFlag_q <= 1'b1;
      end else if (wrTsc && flagOps && ovfArm_q && !wdat[TSC_OVF]) begin
         ovfFlag_q <= 1'b0;
      end
   end

   // buffered pairs: lead channel 2p, follower 2p+1
   for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      logic wrLead;
      logic wrOdd;
      logic lastOdd_q;
      logic actOdd_q;

      // link takes priority on the lead
      assign linked[p] =
         tpc_decode_mode(ctl[2*p], 1'b1) == MODE_BUF;
      assign wrLead = wrEn && (chHit(ap_q.addr, 2*p, CH_CMPH) ||
                               chHit(ap_q.addr, 2*p, CH_CMPL));
      assign wrOdd = wrEn && (chHit(ap_q.addr, 2*p+1, CH_CMPH) ||
                              chHit(ap_q.addr, 2*p+1, CH_CMPL));
      assign actOdd[p] = actOdd_q;

      // remember which register of the pair was written last
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            lastOdd_q <= 1'b0;
         end else if (!linked[p]) begin
            lastOdd_q <= 1'b0;
         end else if (wrOdd) begin
            lastOdd_q <= 1'b1;
         end else if (wrLead) begin
            lastOdd_q <= 1'b0;
         end
      end

      // hand over only at overflow so a period is never cut
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            actOdd_q <= 1'b0;
         end else if (!linked[p]) begin
            actOdd_q <= 1'b0;
         end else if (ovfEv) begin
            actOdd_q <= lastOdd_q;
         end
      end
   end

   // per-channel control, compare, flag and output
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      localparam bit LEAD = (c % 2) == 0;
      tpc_chctl_s ctl_q;
      logic [CW-1:0] cmp_q;
      logic flag_q;
      logic arm_q;
      logic [CW-1:0] effCmp;
      logic active;
      logic match;
      logic wrCtl;
      logic setFlag;
      tpc_mode_e mode;

      assign ctl[c] = ctl_q;
      assign cmp[c] = cmp_q;
      assign chFlag[c] = flag_q;
      assign mode = tpc_decode_mode(ctl_q, LEAD);
      assign wrCtl = wrEn && chHit(ap_q.addr, c, CH_CTL);

      // a linked lead compares against the active register
      if (LEAD) begin : g_lead
         assign effCmp = (linked[c/2] && actOdd[c/2]) ?
                         cmp[c+1] : cmp_q;
         assign active = mode != MODE_OFF;
      end else begin : g_odd
         assign effCmp = cmp_q;
         assign active = (mode != MODE_OFF) && !linked[c/2];
      end

      assign match = tick && active && (count == effCmp);
      assign setFlag = match;

      // control bits; odd control is ignored while linked
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            ctl_q <= '0;
         end else if (wrCtl) begin
            ctl_q <= tpc_chctl_s'(wdat[CH_FIELD_MSB:0]);
         end
      end

      // no shadow: new value applies to the very next compare
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            cmp_q <= '0;
         end else if (wrEn && chHit(ap_q.addr, c, CH_CMPH)) begin
            cmp_q[15:8] <= wdat;
         end else if (wrEn && chHit(ap_q.addr, c, CH_CMPL)) begin
            cmp_q[7:0] <= wdat;
         end
      end

      // two-step clear arming
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            arm_q <= 1'b0;
         end else if (setFlag) begin
            arm_q <= 1'b0;
         end else if (rdNow && chHit(ra, c, CH_CTL) && flag_q && flagOps) begin
            arm_q <= 1'b1;
         end else if (wrCtl && flagOps) begin
            arm_q <= 1'b0;
         end
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            flag_q <= 1'b0;
         end else if (setFlag) begin
            flag_q <= 1'b1;
         end else if (wrCtl && flagOps && arm_q && !wdat[CH_FLAG]) begin
            flag_q <= 1'b0;
         end
      end

      tpc_channel u_chan (
         .mclk(mclk),
         .rst(rst),
         .active(active),
         .ovf(ovfEv),
         .match(match),
         .edgeLevel(ctl_q.edgeLevel),
         .toggleOnOvf(ctl_q.toggleOnOvf),
         .fullDuty(ctl_q.fullDuty),
         .pwmOut(chanOut[c])
      );
   end

   // interrupt requests and wake request, all registered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ovfIrq <= 1'b0;
         chanIrq <= '0;
         wakeReq <= 1'b0;
      end else begin
         ovfIrq <= ovfFlag_q && ovfIe_q && !modInhibit_q;
         for (int c = 0; c < NCH; c++) begin
            chanIrq[c] <= chFlag[c] && ctl[c].irqEn;
         end
         wakeReq <= (ovfFlag_q && ovfIe_q && !modInhibit_q) ||
                    ((chFlag[0] && ctl[0].irqEn) ||
                     (chFlag[1] && ctl[1].irqEn) ||
                     (chFlag[2] && ctl[2].irqEn) ||
                     (chFlag[3] && ctl[3].irqEn));
      end
   end
endmodule : tpc_timer_pwm
`default_nettype wire

//--- verification/tpc_timer_pwm_chk.sv
// port-level checks for the timer pwm block
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_pwm_chk
   import tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic breakActive,
   input wire logic stopMode,
   input wire logic [NCH-1:0] chanOut,
   input wire logic ovfIrq,
   input wire logic [NCH-1:0] chanIrq,
   input wire logic wakeReq
);
   logic apWr_q;
   logic [7:0] apAddr_q;
   logic oie_q;
   logic inh_q;
   tpc_chctl_s ctl_q [NCH];
   logic apTsc;
   logic lnk0;
   logic lnk2;
   logic hold0;
   logic full0;
   logic [NCH-1:0] irqEn;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // write address phases that may gate or clear the overflow flag
   assign apTsc = hsel && hready && htrans[1] && hwrite &&
      (haddr[7:0] == OFF_TSC || haddr[7:0] == OFF_MODH);

   // remember the address phase for its data phase
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         apWr_q <= 1'b0;
         apAddr_q <= 8'h00;
      end else begin
         apWr_q <= hsel && hready && htrans[1] && hwrite;
         apAddr_q <= haddr[7:0];
      end
   end

   // shadow of the control bits, updated on the same edge as the block
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         oie_q <= 1'b0;
         inh_q <= 1'b0;
         for (int c = 0; c < NCH; c++) begin
            ctl_q[c] <= '0;
         end
      end else if (apWr_q) begin
         if (apAddr_q == OFF_TSC) begin
            oie_q <= hwdata[TSC_OIE];
         end
         if (apAddr_q == OFF_MODH) begin
            inh_q <= 1'b1;
         end
         if (apAddr_q == OFF_MODL) begin
            inh_q <= 1'b0;
         end
         for (int c = 0; c < NCH; c++) begin
            if (apAddr_q == OFF_CH_BASE + CH_STRIDE * 8'(c) + CH_CTL) begin
               ctl_q[c] <= tpc_chctl_s'(hwdata[CH_FIELD_MSB:0]);
            end
         end
      end
   end

   // decoded conditions; full duty loses to the set-on-match code and to a channel with mode off
   assign lnk0 = ctl_q[0].link;
   assign lnk2 = ctl_q[2].link;
   assign hold0 = !ctl_q[0].toggleOnOvf && ctl_q[0].edgeLevel == ELS_CLR &&
      !ctl_q[0].fullDuty;
   assign full0 = ctl_q[0].fullDuty && ctl_q[0].edgeLevel != ELS_SET &&
      (ctl_q[0].link || ctl_q[0].modeLsb);
   assign irqEn = {ctl_q[3].irqEn, ctl_q[2].irqEn, ctl_q[1].irqEn,
      ctl_q[0].irqEn};

   odd_idle_a: assert property (
      (lnk0 && $past(lnk0) |-> !chanOut[1]) and
      (lnk2 && $past(lnk2) |-> !chanOut[3]))
      else $error("odd channel of a linked pair drives its output");
   hold_low_a: assert property (
      hold0 && $past(hold0) && $past(hold0, 2) |-> !$rose(chanOut[0]))
      else $error("output rose without toggle on overflow");
   full_duty_a: assert property (
      $past(full0) && $past(full0, 2) |-> chanOut[0])
      else $error("full duty output is low");
   ovf_gate_a: assert property (
      ovfIrq |-> $past(oie_q) && !$past(inh_q))
      else $error("overflow irq while disabled or inhibited");
   chan_gate_a: assert property (
      (chanIrq & ~$past(irqEn)) == 4'h0)
      else $error("channel irq without its enable");
   wake_req_a: assert property (
      ovfIrq || chanIrq != 4'h0 |-> ##[0:1] wakeReq)
      else $error("irq pending without wake request");
   stop_hold_a: assert property (
      stopMode && $past(stopMode) && $past(stopMode, 2) &&
      $past(stopMode, 3) && !$past(apWr_q) && !$past(apWr_q, 2)
      |-> $stable(chanOut) && $stable(ovfIrq) && $stable(chanIrq))
      else $error("outputs moved in stop mode");
   break_hold_a: assert property (
      breakActive && $past(breakActive) && $past(breakActive, 2) &&
      $past(breakActive, 3) && !$past(apWr_q) && !$past(apWr_q, 2)
      |-> $stable(chanOut) && $stable(ovfIrq) && $stable(chanIrq))
      else $error("outputs moved during break");
   ovf_clear_a: assert property (
      $fell(ovfIrq) |-> $past(apTsc, 2) || $past(apTsc, 3) ||
      $past(apTsc, 4))
      else $error("overflow irq dropped without a control write");
endmodule : tpc_timer_pwm_chk
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the timer pwm block over its register bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tpc_pkg::*;
   localparam int MODV = 9;
   localparam int P = MODV + 1;
   localparam int CA = 4;
   localparam int CB = 1;
   localparam int CC = 6;
   localparam int CD = 7;
   localparam logic [7:0] CFG [5] = '{8'h1a, 8'h1e, 8'h1b, 8'h18, 8'h02};
   localparam int HI [5] = '{CA + 1, P - CA - 1, P, 0, 0};
   logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic breakActive, stopMode, ovfIrq, wakeReq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, cntA, cntB;
   logic [NCH-1:0] chanOut, chanIrq;
   int error_cnt, checks_done;

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   tpc_timer_pwm uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .breakActive(breakActive), .stopMode(stopMode),
      .chanOut(chanOut), .ovfIrq(ovfIrq), .chanIrq(chanIrq),
      .wakeReq(wakeReq));

   // 20 mhz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   // one single transfer; entered and left just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      xfer(a, 1'b1, {24'h0, d}, x);
   endtask : wr

   task automatic rdc(input string what, input logic [7:0] a,
                      input logic [7:0] exp);
      logic [31:0] x;
      xfer(a, 1'b0, 32'h0, x);
      check(what, x, {24'h0, exp});
      check("resp", 32'(hresp), 0);
   endtask : rdc

   function automatic logic [7:0] chA(input int c, input logic [7:0] sub);
      return OFF_CH_BASE + CH_STRIDE * 8'(c) + sub;
   endfunction : chA

   task automatic setCmp(input int c, input int v);
      wr(chA(c, CH_CMPH), 8'h00);
      wr(chA(c, CH_CMPL), 8'(v));
   endtask : setCmp

   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask : waitc

   // high time and pulse count over ten periods after two to settle
   task automatic duty(input int ch, input int hi);
      int h;
      int r;
      logic prev;
      h = 0;
      r = 0;
      waitc(2 * P);
      @(negedge mclk);
      prev = chanOut[ch];
      repeat (10 * P) begin
         @(negedge mclk);
         if (chanOut[ch] === 1'b1) h++;
         if (chanOut[ch] === 1'b1 && prev === 1'b0) r++;
         prev = chanOut[ch];
      end
      check("high cycles", 32'(h), 32'(10 * hi));
      check("pulses", 32'(r), (hi > 0 && hi < P) ? 32'd10 : 32'd0);
      @(posedge mclk);
   endtask : duty

   // irq outputs {overflow, channels, wake}, sampled off the edge
   task automatic irqs(input logic [5:0] exp);
      waitc(2);
      @(negedge mclk);
      check("irq outputs", {26'h0, ovfIrq, chanIrq, wakeReq}, {26'h0, exp});
      @(posedge mclk);
   endtask : irqs

   // hang guard, far beyond the few thousand cycles the run needs
   initial begin
      #(20000 * 50);
      error_cnt++;
      $display("[FAIL] watchdog expected finish seen timeout");
      test_done();
   end

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      breakActive = 1'b0;
      stopMode = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdc("tsc reset", OFF_TSC, 8'(HALT_RST) << TSC_HALT);
      rdc("modulo reset", OFF_MODH, MOD_RST[15:8]);
      wr(8'h5c, 8'h5a);
      rdc("unmapped", 8'h5c, 8'h00);
      // halt, clear, period, width, mode, then run
      wr(OFF_TSC, 8'h30);
      wr(OFF_MODH, 8'h00);
      wr(OFF_MODL, 8'(MODV));
      setCmp(0, CA);
      for (int i = 0; i < 5; i++) begin
         wr(chA(0, CH_CTL), CFG[i]);
         if (i == 0) wr(OFF_TSC, 8'h00);
         duty(0, HI[i]);
      end
      // unbuffered rewrite takes effect without a shadow
      wr(chA(0, CH_CTL), CFG[0]);
      setCmp(0, CD);
      duty(0, CD + 1);
      // both linked pairs, lead with both mode bits and with link alone
      for (int p = 0; p < 4; p += 2) begin
         setCmp(p, CA);
         wr(chA(p + 1, CH_CTL), 8'h1a);
         wr(chA(p, CH_CTL), p == 0 ? 8'h3a : 8'h2a);
         duty(p, CA + 1);
         duty(p + 1, 0);
         setCmp(p + 1, CB);
         duty(p, CB + 1);
         setCmp(p, CC);
         duty(p, CC + 1);
      end
      // flags and irq requests
      wr(chA(0, CH_CTL), 8'h7a);
      wr(OFF_TSC, 8'h40);
      irqs(6'b1_0001_1);
      rdc("chan flag", chA(0, CH_CTL), 8'hfa);
      rdc("ovf flag", OFF_TSC, 8'hc0);
      waitc(P + 2);
      wr(OFF_TSC, 8'h40);
      rdc("clear cancelled", OFF_TSC, 8'hc0);
      wr(OFF_TSC, 8'he0);
      rdc("arm", OFF_TSC, 8'he0);
      wr(OFF_TSC, 8'h60);
      rdc("ovf cleared", OFF_TSC, 8'h60);
      rdc("chan arm", chA(0, CH_CTL), 8'hfa);
      wr(chA(0, CH_CTL), 8'h7a);
      irqs(6'b0_0000_0);
      // modulo high write gates the overflow flag until the low byte
      wr(OFF_MODH, 8'h00);
      wr(OFF_TSC, 8'h40);
      waitc(3 * P);
      rdc("ovf inhibited", OFF_TSC, 8'h40);
      irqs(6'b0_0001_1);
      wr(OFF_MODL, 8'(MODV));
      waitc(2 * P);
      irqs(6'b1_0001_1);
      // the counter freezes in stop and in break, then runs on
      for (int k = 0; k < 2; k++) begin
         {breakActive, stopMode} <= 2'(1 << k);
         waitc(4);
         xfer(OFF_CNT, 1'b0, 32'h0, cntA);
         waitc(20);
         xfer(OFF_CNT, 1'b0, 32'h0, cntB);
         check("frozen count", cntB, cntA);
         {breakActive, stopMode} <= 2'b00;
         waitc(2);
         xfer(OFF_CNT, 1'b0, 32'h0, cntA);
         xfer(OFF_CNT, 1'b0, 32'h0, cntB);
         check("count runs", 32'(cntA != cntB), 32'h1);
      end
      // armed clear survives a protected break and completes after it
      wr(OFF_TSC, 8'h60);
      rdc("arm", OFF_TSC, 8'he0);
      breakActive <= 1'b1;
      wr(OFF_TSC, 8'h60);
      rdc("flag kept", OFF_TSC, 8'he0);
      breakActive <= 1'b0;
      wr(OFF_TSC, 8'h60);
      rdc("flag cleared", OFF_TSC, 8'h60);
      // with clearing enabled a break clear sticks
      wr(OFF_TSC, 8'h40);
      waitc(2 * P);
      wr(OFF_TSC, 8'h60);
      wr(OFF_BRK, 8'h80);
      breakActive <= 1'b1;
      rdc("arm in break", OFF_TSC, 8'he0);
      wr(OFF_TSC, 8'h60);
      breakActive <= 1'b0;
      rdc("stays cleared", OFF_TSC, 8'h60);
      rdc("clear enable", OFF_BRK, 8'h80);
      test_done();
   end
endmodule : testbench

bind tpc_timer_pwm tpc_timer_pwm_chk chk (.mclk(mclk), .rst(rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .breakActive(breakActive),
   .stopMode(stopMode), .chanOut(chanOut), .ovfIrq(ovfIrq),
   .chanIrq(chanIrq), .wakeReq(wakeReq));
`default_nettype wire
